// *** hdl/prp_pkg.sv ***
// Shared constants and types of the port traffic rate policer
package prp_pkg;
    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int WINDOW_MS = 1000;
    localparam int WINDOW_CYC = CLK_HZ / 1000 * WINDOW_MS;
    localparam int REFILL_US = 1000;
    localparam int REFILL_CYC = CLK_HZ / 1_000_000 * REFILL_US;
    // Bandwidth granule and credit bucket
    localparam int GRANULE_BITS = 16_000;
    localparam int REFILL_BYTES = GRANULE_BITS / 8 * REFILL_US / 1_000_000;
    localparam int CREDIT_SHIFT = 5;
    localparam int CREDIT_W = 21;
    // Limits
    localparam logic [31:0] STORM_MAX = 32'h0000_1388;
    localparam logic [31:0] BW_MAX = 32'h0000_F424;
    localparam logic [12:0] CNT_SAT = 13'h1FFF;
    // Register byte offsets
    localparam logic [5:0] OFS_PORT_SEL = 6'h00;
    localparam logic [5:0] OFS_STORM_BC = 6'h04;
    localparam logic [5:0] OFS_STORM_MC = 6'h08;
    localparam logic [5:0] OFS_STORM_MISS = 6'h0C;
    localparam logic [5:0] OFS_GROUP = 6'h10;
    localparam logic [5:0] OFS_INGRESS = 6'h14;
    localparam logic [5:0] OFS_EGRESS = 6'h18;
    localparam logic [5:0] OFS_VIEW = 6'h1C;
    localparam logic [5:0] OFS_DROPS = 6'h20;
    // Group register fields
    localparam int GRP_MASK_LSB = 0;
    localparam int GRP_LIM_LSB = 16;
    // Reset values
    localparam logic [12:0] THR_RST = 13'h0000;
    localparam logic [15:0] LIM_RST = 16'h0000;
    // Packet kinds
    typedef enum logic [1:0] {
        PRP_BCAST = 2'h0,
        PRP_MCAST = 2'h1,
        PRP_LOOKUP_MISS = 2'h2,
        PRP_OTHER = 2'h3
    } prp_kind_t;
    // Packet descriptor
    typedef struct packed {
        logic [2:0] port;
        prp_kind_t kind;
        logic [10:0] len;
    } prp_desc_t;
endpackage

// *** hdl/prp_policer.sv ***
// Storm control and bandwidth limiting for switch ports below NPORTS (default 6); other ports pass unpoliced
// ***************************************************************
// ***************************************************************
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps

// ***************************************************************
// Descriptor FIFO
// ***************************************************************
module prp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic room_reg, room_next, avail_reg, avail_next;
    logic push, pop;

    assign in_ready = room_reg;
    assign out_valid = avail_reg;
    assign out_data = mem[rd_reg];

    always_comb
    begin
        push = in_valid & room_reg;
        pop = out_ready & avail_reg;
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        room_next = cnt_next != (AW+1)'(DEPTH);
        avail_next = cnt_next != '0;
    end

    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
            room_reg <= 1'b1;
            avail_reg <= 1'b0;
        end
        else
        begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
            room_reg <= room_next;
            avail_reg <= avail_next;
        end
    end
endmodule

// ***************************************************************
// Policer top
// ***************************************************************
module prp_policer #(
    parameter int NPORTS = 6,
    parameter int WINDOW_CYCLES = prp_pkg::WINDOW_CYC,
    parameter int REFILL_CYCLES = prp_pkg::REFILL_CYC,
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Avalon-MM register slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Receive descriptors in
    input wire logic rx_valid,
    input wire prp_pkg::prp_desc_t rx_desc,
    output logic rx_ready,
    // Receive verdicts out
    output logic rx_res_valid,
    output logic rx_res_pass,
    output prp_pkg::prp_desc_t rx_res_desc,
    input wire logic rx_res_ready,
    // Transmit descriptors and verdicts
    input wire logic tx_valid,
    input wire prp_pkg::prp_desc_t tx_desc,
    output logic tx_res_valid,
    output logic tx_res_pass
);
    import prp_pkg::*;

    typedef logic [CREDIT_W-1:0] prp_cred_t;

    // Configuration state
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [NPORTS-1:0] sel_reg, sel_next;
    logic [2:0] view_reg, view_next;
    logic [2:0][12:0] thr_reg [NPORTS], thr_next [NPORTS];
    logic [2:0] gmask_reg [NPORTS], gmask_next [NPORTS];
    logic [12:0] glim_reg [NPORTS], glim_next [NPORTS];
    logic [15:0] ilim_reg [NPORTS], ilim_next [NPORTS];
    logic [15:0] elim_reg [NPORTS], elim_next [NPORTS];
    // Policing state
    logic [31:0] win_reg, win_next, ref_reg, ref_next, drops_reg, drops_next;
    logic [2:0][12:0] cnt_reg [NPORTS], cnt_next [NPORTS];
    logic [12:0] gcnt_reg [NPORTS], gcnt_next [NPORTS];
    prp_cred_t icred_reg [NPORTS], icred_next [NPORTS];
    prp_cred_t ecred_reg [NPORTS], ecred_next [NPORTS];
    logic rv_reg, rv_next, rp_reg, rp_next, tv_reg, tv_next, tp_reg, tp_next;
    prp_desc_t rd_reg, rd_next;
    // FIFO drain side
    logic f_valid, f_pop;
    prp_desc_t f_desc;
    logic [$bits(prp_desc_t)-1:0] f_bits;
    logic win_tick, ref_tick;

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;
    assign rx_res_valid = rv_reg;
    assign rx_res_pass = rp_reg;
    assign rx_res_desc = rd_reg;
    assign tx_res_valid = tv_reg;
    assign tx_res_pass = tp_reg;
    assign f_desc = prp_desc_t'(f_bits);
    assign f_pop = f_valid & (~rv_reg | rx_res_ready);
    assign win_tick = win_reg == 32'(WINDOW_CYCLES - 1);
    assign ref_tick = ref_reg == 32'(REFILL_CYCLES - 1);

    prp_fifo #(
        .WIDTH($bits(prp_desc_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(rx_valid),
        .in_data(rx_desc),
        .in_ready(rx_ready),
        .out_valid(f_valid),
        .out_data(f_bits),
        .out_ready(f_pop)
    );

    // Refill a bucket by one millisecond of rate, capped at burst size
    function automatic prp_cred_t refill(prp_cred_t c, logic [15:0] lim);
        logic [CREDIT_W:0] sum;
        logic [CREDIT_W:0] cap;
        sum = {1'b0, c} + (CREDIT_W+1)'(lim * REFILL_BYTES);
        cap = (CREDIT_W+1)'(lim) << CREDIT_SHIFT;
        refill = (sum > cap) ? cap[CREDIT_W-1:0] : sum[CREDIT_W-1:0];
    endfunction

    // ***************************************************************
    // Register access
    // ***************************************************************
    always_comb
    begin
        int vp;
        vp = (int'(view_reg) < NPORTS) ? int'(view_reg) : 0;
        wait_next = !((avs_read || avs_write) && wait_reg);
        rdata_next = rdata_reg;
        sel_next = sel_reg;
        view_next = view_reg;
        thr_next = thr_reg;
        gmask_next = gmask_reg;
        glim_next = glim_reg;
        ilim_next = ilim_reg;
        elim_next = elim_reg;
        if (avs_read && wait_reg)
        begin
            unique case (avs_address)
                OFS_PORT_SEL: rdata_next = 32'(sel_reg);
                OFS_STORM_BC: rdata_next = 32'(thr_reg[vp][0]);
                OFS_STORM_MC: rdata_next = 32'(thr_reg[vp][1]);
                OFS_STORM_MISS: rdata_next = 32'(thr_reg[vp][2]);
                OFS_GROUP: rdata_next = (32'(glim_reg[vp]) << GRP_LIM_LSB)
                    | (32'(gmask_reg[vp]) << GRP_MASK_LSB);
                OFS_INGRESS: rdata_next = 32'(ilim_reg[vp]);
                OFS_EGRESS: rdata_next = 32'(elim_reg[vp]);
                OFS_VIEW: rdata_next = 32'(view_reg);
                OFS_DROPS: rdata_next = drops_reg;
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        if (avs_write && !wait_reg)
        begin
            if (avs_address == OFS_PORT_SEL)
                sel_next = avs_writedata[NPORTS-1:0];
            if (avs_address == OFS_VIEW)
                view_next = avs_writedata[2:0];
            for (int p = 0; p < NPORTS; p++)
            begin
                if (sel_reg[p])
                begin
                    for (int t = 0; t < 3; t++)
                    begin
                        if (avs_address == OFS_STORM_BC + 6'(4 * t)
                            && avs_writedata <= STORM_MAX)
                            thr_next[p][t] = avs_writedata[12:0];
                    end
                    if (avs_address == OFS_GROUP
                        && 32'(avs_writedata[28:GRP_LIM_LSB]) <= STORM_MAX)
                    begin
                        gmask_next[p] = avs_writedata[GRP_MASK_LSB+:3];
                        glim_next[p] = avs_writedata[28:GRP_LIM_LSB];
                    end
                    if (avs_address == OFS_INGRESS
                        && avs_writedata <= BW_MAX)
                        ilim_next[p] = avs_writedata[15:0];
                    if (avs_address == OFS_EGRESS
                        && avs_writedata <= BW_MAX)
                        elim_next[p] = avs_writedata[15:0];
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            sel_reg <= '0;
            view_reg <= 3'h0;
            for (int p = 0; p < NPORTS; p++)
            begin
                thr_reg[p] <= {3{THR_RST}};
                gmask_reg[p] <= 3'h0;
                glim_reg[p] <= THR_RST;
                ilim_reg[p] <= LIM_RST;
                elim_reg[p] <= LIM_RST;
            end
        end
        else
        begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            sel_reg <= sel_next;
            view_reg <= view_next;
            thr_reg <= thr_next;
            gmask_reg <= gmask_next;
            glim_reg <= glim_next;
            ilim_reg <= ilim_next;
            elim_reg <= elim_next;
        end
    end

    // ***************************************************************
    // Policing
    // ***************************************************************
    always_comb
    begin
        int p;
        int k;
        logic ok;
        p = int'(f_desc.port);
        k = int'(f_desc.kind);
        ok = 1'b1;
        win_next = win_tick ? 32'h0000_0000 : win_reg + 32'h0000_0001;
        ref_next = ref_tick ? 32'h0000_0000 : ref_reg + 32'h0000_0001;
        drops_next = drops_reg;
        cnt_next = cnt_reg;
        gcnt_next = gcnt_reg;
        icred_next = icred_reg;
        ecred_next = ecred_reg;
        for (int q = 0; q < NPORTS; q++)
        begin
            if (win_tick)
            begin
                cnt_next[q] = '0;
                gcnt_next[q] = '0;
            end
            if (ref_tick)
            begin
                icred_next[q] = refill(icred_reg[q], ilim_reg[q]);
                ecred_next[q] = refill(ecred_reg[q], elim_reg[q]);
            end
        end
        if (f_pop && p < NPORTS)
        begin
            if (f_desc.kind != PRP_OTHER)
            begin
                if (cnt_next[p][k] != CNT_SAT)
                    cnt_next[p][k] = cnt_next[p][k] + 13'h0001;
                if (gmask_reg[p][k] && glim_reg[p] != '0)
                begin
                    ok = gcnt_next[p] < glim_reg[p];
                    if (gcnt_next[p] != CNT_SAT)
                        gcnt_next[p] = gcnt_next[p] + 13'h0001;
                end
                else if (thr_reg[p][k] != '0)
                    ok = cnt_reg[p][k] < thr_reg[p][k] || win_tick;
            end
            if (ok && ilim_reg[p] != '0)
            begin
                ok = icred_next[p] >= CREDIT_W'(f_desc.len);
                if (ok)
                    icred_next[p] = icred_next[p] - CREDIT_W'(f_desc.len);
            end
        end
        if (f_pop && !ok)
            drops_next = drops_reg + 32'h0000_0001;
        rv_next = f_pop ? 1'b1 : (rx_res_ready ? 1'b0 : rv_reg);
        rp_next = f_pop ? ok : rp_reg;
        rd_next = f_pop ? f_desc : rd_reg;
        tv_next = tx_valid;
        tp_next = 1'b1;
        if (tx_valid && int'(tx_desc.port) < NPORTS
            && elim_reg[tx_desc.port] != '0)
        begin
            tp_next = ecred_next[tx_desc.port]
                >= CREDIT_W'(tx_desc.len);
            if (tp_next)
                ecred_next[tx_desc.port] = ecred_next[tx_desc.port]
                    - CREDIT_W'(tx_desc.len);
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            win_reg <= 32'h0000_0000;
            ref_reg <= 32'h0000_0000;
            drops_reg <= 32'h0000_0000;
            for (int q = 0; q < NPORTS; q++)
            begin
                cnt_reg[q] <= '0;
                gcnt_reg[q] <= '0;
                icred_reg[q] <= '0;
                ecred_reg[q] <= '0;
            end
            rv_reg <= 1'b0;
            rp_reg <= 1'b0;
            rd_reg <= '0;
            tv_reg <= 1'b0;
            tp_reg <= 1'b0;
        end
        else
        begin
            win_reg <= win_next;
            ref_reg <= ref_next;
            drops_reg <= drops_next;
            cnt_reg <= cnt_next;
            gcnt_reg <= gcnt_next;
            icred_reg <= icred_next;
            ecred_reg <= ecred_next;
            rv_reg <= rv_next;
            rp_reg <= rp_next;
            rd_reg <= rd_next;
            tv_reg <= tv_next;
            tp_reg <= tp_next;
        end
    end

    // ***************************************************************
    // Checks on port 0
    // ***************************************************************
    logic p0_pop;
    assign p0_pop = f_pop && f_desc.port == 3'h0;

    thr_range_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        32'(thr_reg[0][0]) <= STORM_MAX && 32'(thr_reg[0][2]) <= STORM_MAX)
        else $error("storm threshold out of range");
    win_clear_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        win_tick && !f_pop |=> cnt_reg[0] == '0 && gcnt_reg[0] == '0)
        else $error("counts not cleared at second boundary");
    under_thr_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        p0_pop && f_desc.kind == PRP_BCAST && !gmask_reg[0][0]
        && ilim_reg[0] == '0 && cnt_reg[0][0] < thr_reg[0][0]
        |=> rx_res_valid && rx_res_pass)
        else $error("packet under threshold dropped");
    storm_off_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        p0_pop && f_desc.kind == PRP_MCAST && !gmask_reg[0][1]
        && thr_reg[0][1] == '0 && ilim_reg[0] == '0 |=> rx_res_pass)
        else $error("disabled storm type was policed");
    storm_drop_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        p0_pop && f_desc.kind == PRP_BCAST && !gmask_reg[0][0] && !win_tick
        && thr_reg[0][0] != '0 && cnt_reg[0][0] >= thr_reg[0][0]
        |=> rx_res_valid && !rx_res_pass)
        else $error("packet over threshold passed");
    group_drop_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        p0_pop && f_desc.kind == PRP_LOOKUP_MISS && gmask_reg[0][2]
        && !win_tick && glim_reg[0] != '0 && gcnt_reg[0] >= glim_reg[0]
        |=> !rx_res_pass)
        else $error("group limit exceeded");
    refill_a: assert property (@(posedge clock) disable iff (!rst_n)
        ref_tick && !p0_pop && ilim_reg[0] != '0
        |=> icred_reg[0] >= $past(icred_reg[0])
        && icred_reg[0] <= (CREDIT_W'($past(ilim_reg[0])) << CREDIT_SHIFT))
        else $error("ingress bucket refill wrong");
    egress_drop_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        tx_valid && tx_desc.port == 3'h0 && elim_reg[0] != '0 && !ref_tick
        && ecred_reg[0] < CREDIT_W'(tx_desc.len)
        |=> tx_res_valid && !tx_res_pass)
        else $error("egress over budget passed");
    ingress_drop_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        p0_pop && f_desc.kind == PRP_OTHER && ilim_reg[0] != '0 && !ref_tick
        && icred_reg[0] < CREDIT_W'(f_desc.len) |=> !rx_res_pass)
        else $error("ingress over budget passed");
    egress_off_a: assert property (@(posedge clock)
        disable iff (!rst_n)
        tx_valid && tx_desc.port == 3'h0 && elim_reg[0] == '0
        |=> tx_res_valid && tx_res_pass)
        else $error("disabled egress limiter dropped");
endmodule

// *** verif/prp_port_model.sv ***
// Partner model of the switch port receive path
`timescale 1ns/1ps
// ****************************************
// Receive path partner
// ****************************************
module prp_port_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Descriptors out
    output logic rx_valid,
    output prp_pkg::prp_desc_t rx_desc,
    input wire logic rx_ready,
    // Verdicts in
    input wire logic rx_res_valid,
    input wire logic rx_res_pass,
    input wire prp_pkg::prp_desc_t rx_res_desc,
    output logic rx_res_ready,
    // Pacing
    input wire logic stall,
    input wire logic slow
);
    import prp_pkg::*;
    prp_desc_t send_q[$];
    logic [16:0] got_q[$];
    logic tick;
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_valid <= 1'b0;
            rx_desc <= 16'h0000;
            rx_res_ready <= 1'b0;
            tick <= 1'b0;
        end
        else
        begin
            if (rx_res_valid && rx_res_ready)
                got_q.push_back({rx_res_pass, rx_res_desc});
            if (!rx_valid || rx_ready)
            begin
                rx_valid <= send_q.size() > 0;
                if (send_q.size() > 0)
                    rx_desc <= send_q.pop_front();
                else
                    rx_desc <= prp_desc_t'(~rx_desc);
            end
            tick <= !tick;
            rx_res_ready <= !stall && !(slow && tick);
        end
    end
endmodule

// *** verif/tb_port_traffic_rate_policer.sv ***
// Self-checking bench of the port traffic rate policer
`timescale 1ns/1ps
// ****************************************
// Bench top
// ****************************************
module tb_port_traffic_rate_policer;
    import prp_pkg::*;
    localparam int W = 400;
    logic clock, rst_n, avs_read, avs_write, avs_waitrequest;
    logic rx_valid, rx_ready, rx_res_valid, rx_res_pass, rx_res_ready;
    logic tx_valid, tx_res_valid, tx_res_pass, stall, slow;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, seed, rd, drops;
    prp_desc_t rx_desc, rx_res_desc, tx_desc;
    int errors, n_checks, cyc;
    int thr[8][3];
    int cnt[8][3];
    int gcnt[8];
    int glim[8];
    int gmask[8];
    logic [16:0] exp_q[$];

    prp_policer #(.WINDOW_CYCLES(W), .REFILL_CYCLES(20)) prp_policer_i (
        .clock, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .rx_valid,
        .rx_desc, .rx_ready, .rx_res_valid, .rx_res_pass, .rx_res_desc,
        .rx_res_ready, .tx_valid, .tx_desc, .tx_res_valid, .tx_res_pass);
    prp_port_model prp_port_model_i (
        .clock, .rst_n, .rx_valid, .rx_desc, .rx_ready, .rx_res_valid,
        .rx_res_pass, .rx_res_desc, .rx_res_ready, .stall, .slow);

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock)
        if (rst_n)
            cyc <= cyc + 1;

    function void step();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endfunction

    function automatic logic predict(prp_desc_t d);
        int p;
        int k;
        logic ok;
        p = d.port;
        k = d.kind;
        ok = 1'b1;
        if (k < 3 && p < 6)
        begin
            if (gmask[p][k] && glim[p] != 0)
            begin
                ok = gcnt[p] < glim[p];
                gcnt[p]++;
            end
            else
                ok = thr[p][k] == 0 || cnt[p][k] < thr[p][k];
            cnt[p][k]++;
        end
        return ok;
    endfunction

    task report_and_stop();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] e, input string m);
        n_checks++;
        if (got !== e)
        begin
            errors++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, e);
        end
    endtask

    task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata;
        chk(k < 50, 1, "bus hang");
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task cfg(input logic [7:0] m, input logic [5:0] a, input int v);
        bus(1, OFS_PORT_SEL, {24'h000000, m});
        bus(1, a, v);
        for (int p = 0; p < 8; p++)
        begin
            if (m[p] && v <= 5000 && a >= OFS_STORM_BC && a <= OFS_STORM_MISS)
                thr[p][(a - 6'h04) >> 2] = v;
            if (m[p] && a == OFS_GROUP)
                gmask[p] = v & 7;
            if (m[p] && a == OFS_GROUP)
                glim[p] = v >> 16;
        end
    endtask

    task rdchk(input int p, input logic [5:0] a, input int e);
        bus(1, OFS_VIEW, p);
        bus(0, a, 0);
        chk(rd, e, "readback");
    endtask

    task send(input int p, input int k, input int n, input int len,
        input int e);
        prp_desc_t d;
        int l;
        for (int i = 0; i < n; i++)
        begin
            step();
            l = len ? len : 64 + seed[9:0];
            d = '{port: p[2:0], kind: prp_kind_t'(k), len: l[10:0]};
            prp_port_model_i.send_q.push_back(d);
            exp_q.push_back({(e < 0) ? predict(d) : e[0], d});
        end
    endtask

    task flush();
        int k;
        k = 0;
        while (prp_port_model_i.got_q.size() < exp_q.size() && k < 2000)
        begin
            @(posedge clock);
            k++;
        end
        chk(prp_port_model_i.got_q.size(), exp_q.size(), "verdict count");
        while (exp_q.size() > 0 && prp_port_model_i.got_q.size() > 0)
            chk(prp_port_model_i.got_q.pop_front(), exp_q.pop_front(),
                "verdict");
    endtask

    task align();
        @(posedge clock);
        while (cyc % W != 30)
            @(posedge clock);
        foreach (cnt[p, k])
            cnt[p][k] = 0;
        foreach (gcnt[p])
            gcnt[p] = 0;
    endtask

    task txs(input int p, input int len, input logic e);
        @(posedge clock);
        tx_valid <= 1'b1;
        tx_desc <= '{port: p[2:0], kind: PRP_OTHER, len: len[10:0]};
        @(posedge clock);
        tx_valid <= 1'b0;
        tx_desc <= prp_desc_t'(seed[15:0]);
        @(negedge clock);
        chk({tx_res_valid, tx_res_pass}, {1'b1, e}, "egress verdict");
    endtask

    initial
    begin
        #(50 * 20000);
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end

    initial
    begin
        seed = 32'h6E97;
        errors = 0;
        n_checks = 0;
        cyc = 0;
        rst_n = 1'b0;
        {avs_read, avs_write, tx_valid, stall, slow} = 5'h00;
        avs_address = 6'h00;
        avs_writedata = 32'h00000000;
        tx_desc = 16'h0000;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rdchk(0, OFS_STORM_BC, 0);
        rdchk(0, OFS_INGRESS, 0);
        bus(0, 6'h3C, 0);
        chk(rd, 0, "unmapped read");
        cfg(8'h20, OFS_STORM_MC, 5000);
        cfg(8'h20, OFS_STORM_MC, 5001);
        rdchk(5, OFS_STORM_MC, 5000);
        cfg(8'h20, OFS_INGRESS, 62500);
        cfg(8'h20, OFS_INGRESS, 62501);
        rdchk(5, OFS_INGRESS, 62500);
        cfg(8'h20, OFS_EGRESS, 62500);
        cfg(8'h20, OFS_EGRESS, 62501);
        rdchk(5, OFS_EGRESS, 62500);
        cfg(8'h01, OFS_STORM_BC, 3);
        cfg(8'h01, OFS_STORM_MC, 2);
        align();
        slow <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            step();
            send(seed[4], seed[2:1], 1, 0, -1);
        end
        send(0, PRP_BCAST, 4, 64, -1);
        flush();
        align();
        send(0, PRP_BCAST, 3, 64, -1);
        flush();
        cfg(8'h01, OFS_GROUP, 32'h0004_0005);
        align();
        send(0, PRP_BCAST, 3, 64, -1);
        send(0, PRP_LOOKUP_MISS, 3, 64, -1);
        flush();
        cfg(8'h01, OFS_GROUP, 0);
        bus(0, OFS_DROPS, 0);
        drops = rd;
        cfg(8'h01, OFS_INGRESS, 10);
        repeat (400) @(posedge clock);
        send(0, PRP_OTHER, 3, 100, 1);
        send(0, PRP_OTHER, 1, 100, 0);
        send(4, PRP_OTHER, 4, 0, 1);
        flush();
        bus(0, OFS_DROPS, 0);
        chk(rd, drops + 1, "drop count");
        cfg(8'h01, OFS_INGRESS, 0);
        send(0, PRP_OTHER, 6, 1000, 1);
        flush();
        txs(0, 100, 1);
        cfg(8'h01, OFS_EGRESS, 10);
        repeat (400) @(posedge clock);
        for (int i = 0; i < 3; i++)
            txs(0, 100, 1);
        txs(0, 100, 0);
        txs(2, 100, 1);
        txs(3, 100, 1);
        stall <= 1'b1;
        send(4, PRP_OTHER, 40, 0, 1);
        repeat (80) @(posedge clock);
        chk(rx_ready, 0, "fifo full");
        chk(prp_port_model_i.send_q.size() <= 8, 1, "fifo depth");
        stall <= 1'b0;
        flush();
        report_and_stop();
    end
endmodule
